// ### rtl/dsio_pkg.sv
// Package for the dual six-bit I/O port block.
// Assumes the CPU core presents register-file accesses on the instruction clock.
package dsio_pkg;
    // Register file addresses
    localparam logic [7:0] ADDR_STATUS = 8'h03;
    localparam logic [7:0] ADDR_PORT_B = 8'h06;
    localparam logic [7:0] ADDR_PORT_C = 8'h07;
    // Port geometry
    localparam int PIN_W = 6;
    localparam int INPUT_ONLY_BIT = 3;
    // Port B bits carrying pull-up and wake-on-change (0,1,3,4)
    localparam logic [5:0] PB_WEAK_MASK = 6'h1B;
    // Reset values
    localparam logic [5:0] DIR_RESET = 6'h3F;
    localparam logic [7:0] OPT_RESET = 8'hFF;
    // Option register field positions
    localparam int OPT_WAKE_N = 7;
    localparam int OPT_PULL_N = 6;
    localparam int OPT_TCS = 5;
    // Status bit driven by this block
    localparam int STAT_WAKE = 7;
    // Timer external clock pin position on port C
    localparam int TCLK_BIT = 5;
    // Direction-load target selectors
    localparam logic [2:0] DIR_SEL_B = 3'h6;
    localparam logic [2:0] DIR_SEL_C = 3'h7;
    // Pin-resolution states
    typedef enum logic [1:0] {DSIO_OWN_ANALOG, DSIO_OWN_PERIPH, DSIO_OWN_PORT} dsio_owner_t;
endpackage : dsio_pkg

// ### rtl/dsio_pin_if.sv
// Interface carrying one port's latch, direction and override state to its pin slice.
// Assumes one six-bit port per instance.
`timescale 1ns/1ps
interface dsio_pin_if;
    logic [5:0] outLatch; // Output data latch
    logic [5:0] dirBits; // Effective direction, one = input
    logic [5:0] altSel; // Pin owned by alternate function
    logic [5:0] altOe; // Alternate function drive enable
    logic [5:0] altOut; // Alternate function drive value
    logic [5:0] pinOut; // Resolved pin value
    logic [5:0] pinOe; // Resolved pin enable
    modport ctrl (output outLatch, dirBits, altSel, altOe, altOut, input pinOut, pinOe);
    modport pins (input outLatch, dirBits, altSel, altOe, altOut, output pinOut, pinOe);
endinterface : dsio_pin_if

// ### rtl/dsio_pin_slice.sv
// Per-pin driver resolution for one six-bit port.
// Assumes the top registers the resolved values before they leave the block.
`timescale 1ns/1ps
module dsio_pin_slice
    import dsio_pkg::*;
#(
    parameter logic [5:0] INPUT_ONLY_MASK = 6'h00
) (
    // Port state in, resolved drive out
    dsio_pin_if.pins p
);
    // Fixed precedence: input-only mask first, then alternate function, port direction last
    for (genvar i = 0; i < PIN_W; i++) begin : g_pin
        always_comb begin
            if (INPUT_ONLY_MASK[i]) begin
                // Input-only pin never drives
                p.pinOe[i] = 1'b0; // R5
                p.pinOut[i] = 1'b0;
            end else if (p.altSel[i]) begin
                p.pinOe[i] = p.altOe[i]; // R15
                p.pinOut[i] = p.altOut[i];
            end else begin
                // Zero direction bit drives from the latch
                p.pinOe[i] = ~p.dirBits[i]; // R10
                p.pinOut[i] = p.outLatch[i];
            end
        end
    end
endmodule : dsio_pin_slice

// ### rtl/dsio_port_top.sv
// Functional notes
// R1: Port read returns pin levels, not latch.
// R2: Reset sets all direction bits to one.
// R3: Port B upper two bits read zero.
// R4: Port C upper two bits read zero.
// R5: Port B bit 3 is input only.
// R6: Alternate-function pins read as zero.
// R7: Shared pull-up and wake enables, four pins.
// R8: External reset keeps pull-up, disables wake.
// R9: Direction loaded only by dedicated instruction.
// R10: One means high impedance, zero drives latch.
// R11: Timer options may own clock pin direction.
// R12: Clock source select overrides clock pin direction.
// R13: Reads sample pins, no input latching.
// R14: Output latches hold until rewritten.
// R15: Alternate functions outrank port direction.
// R16: Bit operations rewrite whole latch from pins.
// R17: Write at cycle end, read at start.
// R18: Software separates write and read of port.
// R19: Status top bit marks pin-change wake reset.
// R20: Board must not fight driven pins.
// R21: Pull-up and wake enables are active low.
//
// Top of the dual six-bit I/O port block.
// Assumes the core gives one-cycle strobes per instruction cycle on clk.
`timescale 1ns/1ps
module dsio_port_top
    import dsio_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // Register file access from the core
    input wire logic [7:0] regAddr,
    input wire logic regRd,
    input wire logic regWr,
    input wire logic [7:0] regWrData,
    input wire logic bitOp,
    input wire logic [2:0] bitNum,
    input wire logic bitVal,
    output logic [7:0] regRdData,
    // Direction-load and option-load instructions
    input wire logic dirLoad,
    input wire logic [2:0] dirSel,
    input wire logic optLoad,
    input wire logic [7:0] workReg,
    // Configuration and reset cause
    input wire logic external_reset_select,
    input wire logic wakeReset,
    // Alternate function claims per port
    input wire logic [5:0] altSelB,
    input wire logic [5:0] altOeB,
    input wire logic [5:0] altOutB,
    input wire logic [5:0] altSelC,
    input wire logic [5:0] altOeC,
    input wire logic [5:0] altOutC,
    // Pins
    input wire logic [5:0] pinInB,
    input wire logic [5:0] pinInC,
    output logic [5:0] pinOutB,
    output logic [5:0] pinOeB,
    output logic [5:0] pinOutC,
    output logic [5:0] pinOeC,
    output logic [5:0] pullUpB,
    output logic [5:0] wakeEnB,
    output logic [5:0] pinChange,
    output logic pin_change_wake_flag
);
    // Stored state
    logic [5:0] latchB, latchC; // Output data latches
    logic [5:0] dirB, dirC; // Write-only direction registers
    logic [7:0] optReg; // Write-only option register
    logic [5:0] next_latchB, next_latchC;
    logic [5:0] next_dirB, next_dirC;
    logic [7:0] next_optReg;
    // Registered outputs
    logic [7:0] next_regRdData;
    logic [5:0] next_pullUpB, next_wakeEnB, next_pinChange;
    logic next_wakeFlag;
    // Wake-on-change reference snapshot
    logic [5:0] snapB, next_snapB;
    // Derived views
    logic [5:0] readB, readC; // Read values as seen by the core
    logic [5:0] effDirC; // Direction after timer override
    logic pullOn, wakeOn;
    logic [7:0] rmwByte;

    dsio_pin_if ifB();
    dsio_pin_if ifC();

    // Port B slice; bit 3 is input only
    dsio_pin_slice #(.INPUT_ONLY_MASK(6'h08)) u_sliceB (.p(ifB.pins)); // R5
    dsio_pin_slice #(.INPUT_ONLY_MASK(6'h00)) u_sliceC (.p(ifC.pins));

    // Feed the slices
    assign ifB.outLatch = latchB;
    assign ifB.dirBits = dirB;
    assign ifB.altSel = altSelB;
    assign ifB.altOe = altOeB;
    assign ifB.altOut = altOutB;
    assign ifC.outLatch = latchC;
    assign ifC.dirBits = effDirC;
    assign ifC.altSel = altSelC;
    assign ifC.altOe = altOeC;
    assign ifC.altOut = altOutC;

    // Timer source select forces its clock pin's direction bit to input
    always_comb begin
        effDirC = dirC;
        if (optReg[OPT_TCS]) begin
            effDirC[TCLK_BIT] = 1'b1; // R11 R12
        end
    end

    // Pins sampled directly at the read; alternate pins read zero
    assign readB = pinInB & ~altSelB; // R1 R13 R6
    assign readC = pinInC & ~altSelC; // R1 R13 R6

    // Active-low shared enables from the option register
    assign pullOn = ~optReg[OPT_PULL_N]; // R21
    assign wakeOn = ~optReg[OPT_WAKE_N]; // R21

    // Read-modify-write: start from pins, change one bit
    always_comb begin
        rmwByte = (regAddr == ADDR_PORT_B) ? {2'h0, readB} : {2'h0, readC};
        rmwByte[bitNum] = bitVal; // R16
    end

    // Next state for latches, direction and option
    always_comb begin
        next_latchB = latchB; // R14
        next_latchC = latchC; // R14
        next_dirB = dirB;
        next_dirC = dirC;
        next_optReg = optReg;
        // Writes land at the clock edge ending the cycle
        if (regWr && regAddr == ADDR_PORT_B) begin
            next_latchB = bitOp ? rmwByte[5:0] : regWrData[5:0]; // R17 R16
        end
        if (regWr && regAddr == ADDR_PORT_C) begin
            next_latchC = bitOp ? rmwByte[5:0] : regWrData[5:0]; // R17 R16
        end
        // Only the direction-load instruction reaches the direction bits
        if (dirLoad && dirSel == DIR_SEL_B) begin
            next_dirB = workReg[5:0]; // R9
        end
        if (dirLoad && dirSel == DIR_SEL_C) begin
            next_dirC = workReg[5:0]; // R9
        end
        if (optLoad) begin
            next_optReg = workReg;
        end
    end

    // Read data; direction and option are never readable
    always_comb begin
        next_regRdData = 8'h00;
        if (regRd) begin
            unique case (regAddr)
                ADDR_PORT_B: next_regRdData = {2'h0, readB}; // R3
                ADDR_PORT_C: next_regRdData = {2'h0, readC}; // R4
                ADDR_STATUS: next_regRdData = {pin_change_wake_flag, 7'h00}; // R19
                default: next_regRdData = 8'h00;
            endcase
        end
    end

    // Pull-up and wake enables per pin
    always_comb begin
        next_pullUpB = pullOn ? PB_WEAK_MASK : 6'h00; // R7
        next_wakeEnB = wakeOn ? PB_WEAK_MASK : 6'h00; // R7
        if (external_reset_select) begin
            next_pullUpB[INPUT_ONLY_BIT] = 1'b1; // R8
            next_wakeEnB[INPUT_ONLY_BIT] = 1'b0; // R8
        end
        // Change seen on an enabled pin since the last read of port B
        next_pinChange = (pinInB ^ snapB) & next_wakeEnB;
        next_snapB = (regRd && regAddr == ADDR_PORT_B) ? pinInB : snapB;
        next_wakeFlag = pin_change_wake_flag;
    end

    // Register all state but the wake flag; reset restores direction and option
    always_ff @(posedge clk) begin
        if (!nrst) begin
            latchB <= 6'h00;
            latchC <= 6'h00;
            dirB <= DIR_RESET; // R2
            dirC <= DIR_RESET; // R2
            optReg <= OPT_RESET;
            regRdData <= 8'h00;
            pullUpB <= 6'h00;
            wakeEnB <= 6'h00;
            pinChange <= 6'h00;
            snapB <= 6'h00;
            pinOutB <= 6'h00;
            pinOeB <= 6'h00;
            pinOutC <= 6'h00;
            pinOeC <= 6'h00;
        end else begin
            latchB <= next_latchB;
            latchC <= next_latchC;
            dirB <= next_dirB;
            dirC <= next_dirC;
            optReg <= next_optReg;
            regRdData <= next_regRdData;
            pullUpB <= next_pullUpB;
            wakeEnB <= next_wakeEnB;
            pinChange <= next_pinChange;
            snapB <= next_snapB;
            pinOutB <= ifB.pinOut;
            pinOeB <= ifB.pinOe; // R10
            pinOutC <= ifC.pinOut;
            pinOeC <= ifC.pinOe; // R10
        end
    end

    // Reset cause flag: the reset is synchronous, so its cause is caught while held
    always_ff @(posedge clk) begin
        if (!nrst) begin
            // Set by a pin-change wake reset, cleared by any other reset
            pin_change_wake_flag <= wakeReset; // R19
        end else begin
            // Only a reset moves the flag; software cannot clear it here
            pin_change_wake_flag <= next_wakeFlag;
        end
    end

    // Assertions
    // Register-bus and direction-load steps that several properties start from
    sequence s_read_b;
        regRd && regAddr == ADDR_PORT_B;
    endsequence
    sequence s_read_c;
        regRd && regAddr == ADDR_PORT_C;
    endsequence
    sequence s_read_status;
        regRd && regAddr == ADDR_STATUS;
    endsequence
    sequence s_write_b;
        regWr && regAddr == ADDR_PORT_B;
    endsequence
    sequence s_write_c;
        regWr && regAddr == ADDR_PORT_C;
    endsequence
    sequence s_dir_load_b;
        dirLoad && dirSel == DIR_SEL_B;
    endsequence
    sequence s_dir_load_c;
        dirLoad && dirSel == DIR_SEL_C;
    endsequence

    // Direction bits all ones straight after reset
    a_dir_reset_ones: assert property (@(posedge clk) // R2
        $rose(nrst) |-> dirB == DIR_RESET && dirC == DIR_RESET)
        else $error("direction not all ones after reset");
    // Input-only pin never gets its driver enabled
    a_input_only_off: assert property (@(posedge clk) disable iff (!nrst) // R5
        pinOeB[INPUT_ONLY_BIT] == 1'b0)
        else $error("input-only pin driven");
    // Unimplemented upper bits of port B read as zero
    a_port_b_upper: assert property (@(posedge clk) disable iff (!nrst) // R3
        s_read_b |=> regRdData[7:6] == 2'h0)
        else $error("port B upper bits nonzero");
    // Port B read shows pin levels, not the latch
    a_port_b_read: assert property (@(posedge clk) disable iff (!nrst) // R1
        s_read_b |=> regRdData[5:0] == ($past(pinInB) & ~$past(altSelB)))
        else $error("port B read not pin level");
    // Port C read shows pin levels with upper bits zero
    a_port_c_read: assert property (@(posedge clk) disable iff (!nrst) // R4
        s_read_c |=> regRdData == {2'h0, $past(pinInC) & ~$past(altSelC)})
        else $error("port C read wrong");
    // Latches move only on a write
    a_latch_holds: assert property (@(posedge clk) disable iff (!nrst) // R14
        !regWr |=> latchB == $past(latchB) && latchC == $past(latchC))
        else $error("latch changed without write");
    // External reset mode keeps the pull-up and drops the wake
    a_reset_pin_pullup: assert property (@(posedge clk) disable iff (!nrst) // R8
        external_reset_select |=> pullUpB[INPUT_ONLY_BIT] && !wakeEnB[INPUT_ONLY_BIT])
        else $error("reset pin pull-up or wake wrong");
    // Timer clock source keeps its pin an input
    a_tclk_override: assert property (@(posedge clk) disable iff (!nrst) // R12
        optReg[OPT_TCS] && !altSelC[TCLK_BIT] |=> !pinOeC[TCLK_BIT])
        else $error("timer clock pin driven");
    // Cleared direction bit drives the pin from the latch
    a_drive_latch: assert property (@(posedge clk) disable iff (!nrst) // R10
        !dirB[0] && !altSelB[0] |=> pinOeB[0] && pinOutB[0] == $past(latchB[0]))
        else $error("output driver not from latch");
    // Status read carries the wake flag in its top bit
    a_status_read: assert property (@(posedge clk) disable iff (!nrst) // R19
        s_read_status |=> regRdData == {$past(pin_change_wake_flag), 7'h00})
        else $error("status wake bit wrong");
    // Wake flag is fixed between resets
    a_flag_holds: assert property (@(posedge clk) disable iff (!nrst) // R19
        1'b1 |=> $stable(pin_change_wake_flag))
        else $error("wake flag moved without reset");
    // Direction and option are never readable; other addresses read zero
    a_unmapped_zero: assert property (@(posedge clk) disable iff (!nrst) // R9
        regRd && regAddr != ADDR_STATUS && regAddr != ADDR_PORT_B && regAddr != ADDR_PORT_C
        |=> regRdData == 8'h00)
        else $error("unmapped read nonzero");
    // Direction load of port B takes the working register
    a_dir_load_b: assert property (@(posedge clk) disable iff (!nrst) // R9
        s_dir_load_b |=> dirB == $past(workReg[5:0]))
        else $error("port B direction load wrong");
    // Direction load of port C takes the working register
    a_dir_load_c: assert property (@(posedge clk) disable iff (!nrst) // R9
        s_dir_load_c |=> dirC == $past(workReg[5:0]))
        else $error("port C direction load wrong");
    // Nothing but the direction load reaches the direction bits
    a_dir_holds: assert property (@(posedge clk) disable iff (!nrst) // R9
        !dirLoad |=> dirB == $past(dirB) && dirC == $past(dirC))
        else $error("direction changed without load");
    // Plain write to port B lands in its latch at the cycle end
    a_write_b_latch: assert property (@(posedge clk) disable iff (!nrst) // R17
        s_write_b ##0 !bitOp |=> latchB == $past(regWrData[5:0]))
        else $error("port B write not latched");
    // Plain write to port C lands in its latch at the cycle end
    a_write_c_latch: assert property (@(posedge clk) disable iff (!nrst) // R17
        s_write_c ##0 !bitOp |=> latchC == $past(regWrData[5:0]))
        else $error("port C write not latched");
    // Write, then latch, then pin: two steps from strobe to driver
    a_write_to_pin: assert property (@(posedge clk) disable iff (!nrst) // R17
        s_write_b ##0 (!bitOp && !dirLoad && !dirB[1] && !altSelB[1]) ##1 !altSelB[1]
        |=> pinOeB[1] && pinOutB[1] == $past(regWrData[1], 2))
        else $error("written value not on pin");
    // Bit set rewrites the other bits from the pins
    a_rmw_bit_five: assert property (@(posedge clk) disable iff (!nrst) // R16
        s_write_b ##0 (bitOp && bitNum == 3'h5)
        |=> latchB == {$past(bitVal), $past(pinInB[4:0] & ~altSelB[4:0])})
        else $error("bit operation latch wrong");
    // One shared active-low pull-up enable for the four pins
    a_pull_shared: assert property (@(posedge clk) disable iff (!nrst) // R7 R21
        !external_reset_select |=> pullUpB == ($past(optReg[OPT_PULL_N]) ? 6'h00 : PB_WEAK_MASK))
        else $error("pull-up enables wrong");
    // One shared active-low wake enable for the four pins
    a_wake_shared: assert property (@(posedge clk) disable iff (!nrst) // R7 R21
        !external_reset_select |=> wakeEnB == ($past(optReg[OPT_WAKE_N]) ? 6'h00 : PB_WEAK_MASK))
        else $error("wake enables wrong");
    // Set direction bit leaves the pin undriven
    a_input_hiz: assert property (@(posedge clk) disable iff (!nrst) // R10
        dirB[2] && !altSelB[2] |=> !pinOeB[2])
        else $error("input pin driven");
    // Alternate function owns the driver over the direction bit
    a_alt_owns_pin: assert property (@(posedge clk) disable iff (!nrst) // R15
        altSelB[0] |=> pinOeB[0] == $past(altOeB[0]) && pinOutB[0] == $past(altOutB[0]))
        else $error("alternate function lost the pin");
    // Alternate-function pin reads as zero
    a_alt_read_zero: assert property (@(posedge clk) disable iff (!nrst) // R6
        s_read_b ##0 altSelB[0] |=> !regRdData[0])
        else $error("alternate pin read nonzero");
    // Pin changes are only flagged on the four weak pins
    a_change_weak_only: assert property (@(posedge clk) disable iff (!nrst) // R7
        (pinChange & ~PB_WEAK_MASK) == 6'h00)
        else $error("change flagged on plain pin");
endmodule : dsio_port_top

// ### test/dsio_board_model.sv
// Board-side model of one six-bit port's pins.
// Assumes the device drives a pin only while its enable is high.
`timescale 1ns/1ps
module dsio_board_model (
    // Device drive
    input wire logic [5:0] pinOut,
    input wire logic [5:0] pinOe,
    // Board source and resolved level
    input wire logic [5:0] extVal,
    output logic [5:0] pinLevel
);
    // Board yields wherever the device drives, so there is no contention
    always_comb begin
        pinLevel = (pinOe & pinOut) | (~pinOe & extVal);
    end
endmodule : dsio_board_model

// ### test/tb_top.sv
// Self-checking bench for the dual six-bit port block.
// Assumes the board model closes the loop from pin drive to pin level.
`timescale 1ns/1ps
module tb_top
    import dsio_pkg::*;
;
    // Core side
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic regRd = 1'b0, regWr = 1'b0, bitOp = 1'b0, bitVal = 1'b0;
    logic dirLoad = 1'b0, optLoad = 1'b0, external_reset_select = 1'b0, wakeReset = 1'b1;
    logic [7:0] regAddr = 8'h00, regWrData = 8'h00, workReg = 8'h00, regRdData, rdv, a;
    logic [2:0] bitNum = 3'h0, dirSel = 3'h0;
    // Pin side
    logic [5:0] altSelB = 6'h00, extB = 6'h00, extC = 6'h00, pinInB, pinInC, d;
    logic [5:0] altOeB = 6'h00, altOutB = 6'h00;
    logic [5:0] pinOutB, pinOeB, pinOutC, pinOeC, pullUpB, wakeEnB, pinChange;
    logic pin_change_wake_flag;
    int n_fail = 0, checked = 0, cyc = 0;
    // Rows: address, direction, latch, board level
    logic [25:0] rows [5] = '{{8'h06, 6'h00, 6'h2A, 6'h15}, {8'h06, 6'h3F, 6'h3F, 6'h2A},
        {8'h06, 6'h15, 6'h00, 6'h3F}, {8'h07, 6'h00, 6'h15, 6'h2A},
        {8'h07, 6'h2A, 6'h3F, 6'h00}};

    dsio_port_top dut (
        .clk, .nrst, .regAddr, .regRd, .regWr, .regWrData, .bitOp, .bitNum, .bitVal,
        .regRdData, .dirLoad, .dirSel, .optLoad, .workReg, .external_reset_select,
        .wakeReset, .altSelB, .altOeB, .altOutB, .altSelC(6'h00),
        .altOeC(6'h00), .altOutC(6'h00), .pinInB, .pinInC, .pinOutB, .pinOeB,
        .pinOutC, .pinOeC, .pullUpB, .wakeEnB, .pinChange, .pin_change_wake_flag
    );
    dsio_board_model brdB (.pinOut(pinOutB), .pinOe(pinOeB), .extVal(extB), .pinLevel(pinInB));
    dsio_board_model brdC (.pinOut(pinOutC), .pinOe(pinOeC), .extVal(extC), .pinLevel(pinInC));

    // Clock
    always #12.5 clk = ~clk;

    // Hang guard, far above the roughly 70 cycles needed
    always @(posedge clk) begin
        cyc++;
        if (cyc == 3000) begin
            n_fail++;
            tally_and_finish();
        end
    end

    task go;
        @(posedge clk);
        #1;
    endtask : go
    // Each access ends with an idle cycle so pins settle before a read
    task wr(input logic [7:0] ad, input logic [7:0] dat, input logic bo);
        regAddr = ad;
        regWrData = dat;
        bitOp = bo;
        regWr = 1'b1;
        go();
        regWr = 1'b0;
        bitOp = 1'b0;
        go();
    endtask : wr
    task rd(input logic [7:0] ad);
        regAddr = ad;
        regRd = 1'b1;
        go();
        regRd = 1'b0;
        rdv = regRdData;
        go();
    endtask : rd
    task dl(input logic [2:0] s, input logic [7:0] w);
        dirSel = s;
        workReg = w;
        dirLoad = 1'b1;
        go();
        dirLoad = 1'b0;
        go();
    endtask : dl
    task ol(input logic [7:0] w);
        workReg = w;
        optLoad = 1'b1;
        go();
        optLoad = 1'b0;
        go();
    endtask : ol
    task chk8(input logic [7:0] got, input logic [7:0] exp, input string what);
        checked++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk8
    task chk6(input logic [5:0] got, input logic [5:0] exp, input string what);
        checked++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk6
    task tally_and_finish;
        if (n_fail == 0 && checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : tally_and_finish

    initial begin
        // Reset with a pin-change wake cause
        go();
        go();
        nrst = 1'b1;
        wakeReset = 1'b0;
        go();
        chk6(pinOeB, 6'h00, "oe B after reset");
        chk6(pinOeC, 6'h00, "oe C after reset");
        chk6({5'h00, pin_change_wake_flag}, 6'h01, "wake flag set");
        extB = 6'h2D;
        extC = 6'h12;
        rd(ADDR_PORT_B);
        chk8(rdv, 8'h2D, "read B");
        rd(ADDR_PORT_C);
        chk8(rdv, 8'h12, "read C");
        rd(ADDR_STATUS);
        chk6({5'h00, rdv[STAT_WAKE]}, 6'h01, "status wake bit");
        rd(8'h05);
        chk8(rdv, 8'h00, "unmapped read");
        // Timer pin stays input while clock source select is one
        dl(DIR_SEL_C, 8'h00);
        chk6(pinOeC, 6'h1F, "timer pin owned");
        ol(8'h1F);
        chk6(pullUpB, PB_WEAK_MASK, "pull-ups on");
        chk6(wakeEnB, PB_WEAK_MASK, "wake on");
        external_reset_select = 1'b1;
        go();
        go();
        chk6(wakeEnB, 6'h13, "reset pin wake off");
        ol(8'hFF);
        chk6(pullUpB, 6'h08, "reset pin pull kept");
        chk6(wakeEnB, 6'h00, "wake disabled");
        ol(8'h1F);
        external_reset_select = 1'b0;
        // Ordinary direction and latch cases
        foreach (rows[i]) begin
            a = rows[i][25:18];
            d = rows[i][17:12] | ((a == ADDR_PORT_B) ? 6'h08 : 6'h00);
            extB = rows[i][5:0];
            extC = rows[i][5:0];
            dl((a == ADDR_PORT_B) ? DIR_SEL_B : DIR_SEL_C, {2'b00, rows[i][17:12]});
            wr(a, {2'b00, rows[i][11:6]}, 1'b0);
            rd(a);
            chk8(rdv, {2'b00, (~d & rows[i][11:6]) | (d & rows[i][5:0])}, "row read");
            chk6((a == ADDR_PORT_B) ? pinOeB : pinOeC, ~d, "row enable");
        end
        // Alternate function reads zero and outranks the direction bit
        altSelB = 6'h01;
        altOeB = 6'h01;
        altOutB = 6'h01;
        extB = 6'h3F;
        dl(DIR_SEL_B, 8'h3F);
        rd(ADDR_PORT_B);
        chk8(rdv, 8'h3E, "alt pin read");
        chk6(pinOeB, 6'h01, "alt pin enable");
        chk6(pinOutB, 6'h01, "alt pin value");
        altSelB = 6'h00;
        altOeB = 6'h00;
        altOutB = 6'h00;
        // Bit set copies input pin level into its latch
        dl(DIR_SEL_B, 8'h01);
        wr(ADDR_PORT_B, 8'h00, 1'b0);
        extB = 6'h01;
        bitNum = 3'h5;
        bitVal = 1'b1;
        wr(ADDR_PORT_B, 8'h00, 1'b1);
        dl(DIR_SEL_B, 8'h00);
        chk6(pinOutB, 6'h21, "bit set rewrite");
        // Change on the weak pins since the last port read is flagged
        dl(DIR_SEL_B, 8'h3F);
        extB = 6'h00;
        rd(ADDR_PORT_B);
        extB = 6'h3F;
        go();
        chk6(pinChange, PB_WEAK_MASK, "pin change seen");
        // Plain reset clears the wake flag
        nrst = 1'b0;
        go();
        go();
        nrst = 1'b1;
        go();
        chk6({5'h00, pin_change_wake_flag}, 6'h00, "wake flag clear");
        tally_and_finish();
    end
endmodule : tb_top
